/* File: design/rae_pkg.sv */
package rae_pkg;
	localparam int          NREG         = 4;
	localparam int          AW           = 12;
	localparam int          DMA_CH       = 64;
	localparam int          QDMA_CH      = 8;
	localparam int          CE_W         = 17;
	localparam logic [16:0] CE_VALID     = 17'h1000F;
	localparam int          EVALUATE_BIT_BIT     = 0;
	localparam int          EVALUATE_BIT_RSVD    = 1;
	localparam int          ST_W         = 3;
	localparam int          ST_ERR       = 0;
	localparam int          ST_RSVD      = 1;
	localparam int          ST_DONE      = 2;
	localparam logic [11:0] A_CE_FLAGS   = 12'h000;
	localparam logic [11:0] A_CE_CLR     = 12'h004;
	localparam logic [11:0] A_EVALUATE_BIT       = 12'h008;
	localparam logic [11:0] A_IRQ_STAT   = 12'h00C;
	localparam logic [11:0] A_IRQ_MASK   = 12'h010;
	localparam logic [11:0] A_CH_LO      = 12'h014;
	localparam logic [11:0] A_CH_HI      = 12'h018;
	localparam logic [11:0] A_CH_Q       = 12'h01C;
	localparam logic [11:0] A_ERR_STATE  = 12'h020;
	localparam logic [3:0]  REGION_PAGE  = 4'h1;
	localparam logic [4:0]  R_DMA_EN_LO  = 5'h00;
	localparam logic [4:0]  R_DMA_EN_HI  = 5'h04;
	localparam logic [4:0]  R_QDMA_EN    = 5'h08;
	localparam logic [4:0]  R_VIEW_LO    = 5'h0C;
	localparam logic [4:0]  R_VIEW_HI    = 5'h10;
	localparam logic [4:0]  R_VIEW_Q     = 5'h14;
	localparam logic [63:0] DMA_EN_RST   = 64'h0;
	localparam logic [7:0]  QDMA_EN_RST  = 8'h0;
endpackage : rae_pkg

/* File: design/rae_region_gate.sv */
`timescale 1ns/10ps
module rae_region_gate
(
	input  wire logic [63:0] dma_en,
	input  wire logic [7:0]  qdma_en,
	input  wire logic [63:0] chan_dma,
	input  wire logic [7:0]  chan_qdma,
	input  wire logic [63:0] chan_pend,
	output logic      [63:0] view_dma,
	output logic      [7:0]  view_qdma,
	output logic             done
);
	// masked channels read as zero in this view
	assign view_dma  = chan_dma & dma_en;
	assign view_qdma = chan_qdma & qdma_en;
	// only owned, enabled channels reach this region's completion line
	assign done      = |(chan_pend & chan_dma & dma_en);
endmodule : rae_region_gate

/* File: design/rae_top.sv */
`timescale 1ns/10ps
module rae_top
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] dma_event_miss_low,
	input  wire logic [31:0] dma_event_miss_high,
	input  wire logic [7:0]  qdma_event_miss,
	input  wire logic [16:0] ctrl_err_set,
	input  wire logic [63:0] chan_pend,
	output logic             err_irq,
	output logic [3:0]       region_irq,
	output logic             irq
);
	logic [16:0] ce_q,       ce_d;
	logic        err_any_q,  err_any_d;
	logic        err_irq_q,  err_irq_d;
	logic [2:0]  stat_q,     stat_d;
	logic [2:0]  mask_q,     mask_d;
	logic        irq_q,      irq_d;
	logic [63:0] chan_q,     chan_d;
	logic [7:0]  chq_q,      chq_d;
	logic [63:0] den_q [4];
	logic [63:0] den_d [4];
	logic [7:0]  qen_q [4];
	logic [7:0]  qen_d [4];
	logic [3:0]  rirq_q,     rirq_d;
	logic [31:0] prdata_q,   prdata_d;
	logic        pready_q,   pready_d;
	logic        pslverr_q,  pslverr_d;
	logic [63:0] view_dma [4];
	logic [7:0]  view_q   [4];
	logic [3:0]  done;
	logic        acc;
	logic        wr;
	logic        rg_hit;
	logic [1:0]  ridx;
	logic [4:0]  roff;
	logic        err_now;
	logic        evaluate_bit_wr;
	logic        evaluate_bit_rsvd;
	logic [31:0] rd;
	logic        hit;
	logic [2:0]  ev;

	genvar g;
	generate
		for (g = 0; g < rae_pkg::NREG; g++)
		begin : g_rg
			rae_region_gate u_gate
			(
				.dma_en    (den_q[g]),
				.qdma_en   (qen_q[g]),
				.chan_dma  (chan_q),
				.chan_qdma (chq_q),
				.chan_pend (chan_pend),
				.view_dma  (view_dma[g]),
				.view_qdma (view_q[g]),
				.done      (done[g])
			);
		end
	endgenerate

	always_comb
	begin
		// one wait state: ready is raised the cycle after access starts
		acc       = psel & penable & pready_q;
		wr        = acc & pwrite;
		rg_hit    = (paddr[11:8] == rae_pkg::REGION_PAGE) & ~paddr[7];
		ridx      = paddr[6:5];
		roff      = paddr[4:0];
		pready_d  = psel & penable & ~pready_q;
		rd        = 32'h0000_0000;
		hit       = 1'b1;
		if (rg_hit)
		begin
			unique case (roff)
				rae_pkg::R_DMA_EN_LO: rd = den_q[ridx][31:0];
				rae_pkg::R_DMA_EN_HI: rd = den_q[ridx][63:32];
				rae_pkg::R_QDMA_EN:   rd = {24'h0, qen_q[ridx]};
				rae_pkg::R_VIEW_LO:   rd = view_dma[ridx][31:0];
				rae_pkg::R_VIEW_HI:   rd = view_dma[ridx][63:32];
				rae_pkg::R_VIEW_Q:    rd = {24'h0, view_q[ridx]};
				default:              hit = 1'b0;
			endcase
		end
		else
		begin
			unique case (paddr)
				rae_pkg::A_CE_FLAGS:  rd = {15'h0, ce_q};
				rae_pkg::A_CE_CLR:    rd = 32'h0000_0000;
				rae_pkg::A_EVALUATE_BIT:      rd = 32'h0000_0000;
				rae_pkg::A_IRQ_STAT:  rd = {29'h0, stat_q};
				rae_pkg::A_IRQ_MASK:  rd = {29'h0, mask_q};
				rae_pkg::A_CH_LO:     rd = chan_q[31:0];
				rae_pkg::A_CH_HI:     rd = chan_q[63:32];
				rae_pkg::A_CH_Q:      rd = {24'h0, chq_q};
				rae_pkg::A_ERR_STATE: rd = {31'h0, err_any_q};
				default:              hit = 1'b0;
			endcase
		end
		prdata_d  = (pready_d & ~pwrite & hit) ? rd : 32'h0000_0000;
		pslverr_d = pready_d & ~hit;
	end

	// answer is registered, hence the fixed wait state
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// all region views share the chan_q and chq_q channel registers, the masks pick the bits
	always_comb
	begin
		chan_d = chan_q;
		chq_d  = chq_q;
		den_d  = den_q;
		qen_d  = qen_q;
		if (wr & hit)
		begin
			if (rg_hit)
			begin
				unique case (roff)
					rae_pkg::R_DMA_EN_LO: den_d[ridx][31:0]  = pwdata;
					rae_pkg::R_DMA_EN_HI: den_d[ridx][63:32] = pwdata;
					rae_pkg::R_QDMA_EN:   qen_d[ridx] = pwdata[7:0];
					rae_pkg::R_VIEW_LO:
						chan_d[31:0] = (chan_q[31:0] & ~den_q[ridx][31:0])
							| (pwdata & den_q[ridx][31:0]);
					rae_pkg::R_VIEW_HI:
						chan_d[63:32] = (chan_q[63:32] & ~den_q[ridx][63:32])
							| (pwdata & den_q[ridx][63:32]);
					rae_pkg::R_VIEW_Q:
						chq_d = (chq_q & ~qen_q[ridx]) | (pwdata[7:0] & qen_q[ridx]);
					default: ;
				endcase
			end
			else
			begin
				unique case (paddr)
					rae_pkg::A_CH_LO:    chan_d[31:0] = pwdata;
					rae_pkg::A_CH_HI:    chan_d[63:32] = pwdata;
					rae_pkg::A_CH_Q:     chq_d = pwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			chan_q <= 64'h0;
			chq_q  <= 8'h00;
			for (int i = 0; i < rae_pkg::NREG; i++)
			begin
				den_q[i] <= rae_pkg::DMA_EN_RST;
				qen_q[i] <= rae_pkg::QDMA_EN_RST;
			end
		end
		else
		begin
			chan_q <= chan_d;
			chq_q  <= chq_d;
			den_q  <= den_d;
			qen_q  <= qen_d;
		end
	end

	always_comb
	begin
		ce_d      = ce_q;
		evaluate_bit_wr   = 1'b0;
		evaluate_bit_rsvd = 1'b0;
		if (wr & ~rg_hit)
		begin
			unique case (paddr)
				rae_pkg::A_CE_CLR: ce_d = ce_q & ~(pwdata[16:0] & rae_pkg::CE_VALID);
				rae_pkg::A_EVALUATE_BIT:
				begin
					evaluate_bit_wr   = pwdata[rae_pkg::EVALUATE_BIT_BIT];
					evaluate_bit_rsvd = pwdata[rae_pkg::EVALUATE_BIT_RSVD];
				end
				default: ;
			endcase
		end
		// a new error arriving with a clear survives it
		ce_d      = ce_d | (ctrl_err_set & rae_pkg::CE_VALID);
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			ce_q <= 17'h0_0000;
		end
		else
		begin
			ce_q <= ce_d;
		end
	end

	always_comb
	begin
		err_now   = (|dma_event_miss_low) | (|dma_event_miss_high)
			| (|qdma_event_miss) | (|ce_q);
		err_any_d = err_now;
		// edge of the combined state, so steady errors re-fire only on an evaluate write
		err_irq_d = (err_now & ~err_any_q) | (evaluate_bit_wr & err_now);
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			err_any_q <= 1'b0;
			err_irq_q <= 1'b0;
		end
		else
		begin
			err_any_q <= err_any_d;
			err_irq_q <= err_irq_d;
		end
	end

	always_comb
	begin
		mask_d = mask_q;
		if (wr & ~rg_hit & (paddr == rae_pkg::A_IRQ_MASK))
		begin
			mask_d = pwdata[2:0];
		end
		rirq_d = done;
		ev     = 3'h0;
		ev[rae_pkg::ST_ERR]  = err_irq_d;
		ev[rae_pkg::ST_RSVD] = evaluate_bit_rsvd;
		ev[rae_pkg::ST_DONE] = |(done & ~rirq_q);
		stat_d = stat_q;
		if (wr & ~rg_hit & (paddr == rae_pkg::A_IRQ_STAT))
		begin
			stat_d = stat_q & ~pwdata[2:0];
		end
		// set wins, so an event in the clear cycle is not lost
		stat_d = stat_d | ev;
		// taken from flops, costs a cycle but keeps the pin clean
		irq_d  = |(stat_q & mask_q);
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			stat_q <= 3'h0;
			mask_q <= 3'h0;
			irq_q  <= 1'b0;
			rirq_q <= 4'h0;
		end
		else
		begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q  <= irq_d;
			rirq_q <= rirq_d;
		end
	end

	assign prdata     = prdata_q;
	assign pready     = pready_q;
	assign pslverr    = pslverr_q;
	assign err_irq    = err_irq_q;
	assign region_irq = rirq_q;
	assign irq        = irq_q;
endmodule : rae_top

/* File: test/rae_checker.sv */
`timescale 1ns/10ps
module rae_checker
(
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] dma_event_miss_low,
	input wire logic [63:0] chan_pend,
	input wire logic        err_irq,
	input wire logic [3:0]  region_irq
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	wire logic acc = psel && penable && pready;
	a_err_one_clock: assert property (err_irq |=> !err_irq)
		else $error("err_irq wider than one cycle");
	a_ready_one_clock: assert property (pready |=> !pready)
		else $error("pready wider than one cycle");
	a_ready_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not after one wait state");
	a_slverr_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata nonzero outside answer");
	a_unmapped_region: assert property (acc && paddr[11:7] == 5'h03 |-> pslverr)
		else $error("unmapped region address accepted");
	a_evaluate_bit_repulse: assert property (acc && pwrite && paddr == rae_pkg::A_EVALUATE_BIT && pwdata[0]
		&& (|dma_event_miss_low) |=> err_irq) else $error("evaluate write gave no pulse");
	a_pend_none_quiet: assert property ($past(chan_pend) == 64'h0 |-> region_irq == 4'h0)
		else $error("region_irq without pending channel");
	c_err: cover property (err_irq);
	c_slverr: cover property (pslverr);
	c_region: cover property (|region_irq);
endmodule : rae_checker
bind rae_top rae_checker u_chk
(
	.ref_clk            (ref_clk),
	.sys_rst            (sys_rst),
	.psel               (psel),
	.penable            (penable),
	.pwrite             (pwrite),
	.paddr              (paddr),
	.pwdata             (pwdata),
	.prdata             (prdata),
	.pready             (pready),
	.pslverr            (pslverr),
	.dma_event_miss_low (dma_event_miss_low),
	.chan_pend          (chan_pend),
	.err_irq            (err_irq),
	.region_irq         (region_irq)
);

/* File: test/rae_top_test.sv */
`timescale 1ns/10ps
module rae_top_test;
	logic        ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdat, dma_event_miss_low = '0, dma_event_miss_high = '0;
	logic [7:0]  qdma_event_miss = '0;
	logic [16:0] ctrl_err_set = '0;
	logic [63:0] chan_pend = '0;
	logic        pready, pslverr, serr, err_irq, irq;
	logic [3:0]  region_irq;
	int          mismatches = 0, comparisons = 0, pulses = 0, cyc = 0, p0;
	rae_top u_dut
	(
		.ref_clk             (ref_clk),
		.sys_rst             (sys_rst),
		.psel                (psel),
		.penable             (penable),
		.pwrite              (pwrite),
		.paddr               (paddr),
		.pwdata              (pwdata),
		.prdata              (prdata),
		.pready              (pready),
		.pslverr             (pslverr),
		.dma_event_miss_low  (dma_event_miss_low),
		.dma_event_miss_high (dma_event_miss_high),
		.qdma_event_miss     (qdma_event_miss),
		.ctrl_err_set        (ctrl_err_set),
		.chan_pend           (chan_pend),
		.err_irq             (err_irq),
		.region_irq          (region_irq),
		.irq                 (irq)
	);
	always #5 ref_clk = ~ref_clk;
	// timeout well above the few hundred cycles the sequence needs
	always @(posedge ref_clk)
	begin
		cyc++;
		if (err_irq === 1'b1) pulses++;
		if (cyc == 5000)
		begin
			mismatches++;
			summarize();
		end
	end
	task summarize;
		if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// waits for pready as long as it takes; only the cycle ceiling ends a hang
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rdat = prdata;
		serr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : xfer
	task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		xfer(0, a, 32'h0);
		chk(nm, rdat, e);
	endtask : rchk
	task pchk(input int e);
		repeat (4) @(posedge ref_clk);
		chk("err_irq", 32'(pulses - p0), 32'(e));
		p0 = pulses;
	endtask : pchk
	function automatic logic [11:0] ra(input int r, input logic [4:0] o);
		return {rae_pkg::REGION_PAGE, 3'(r), o};
	endfunction : ra
	initial
	begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 0;
		for (int r = 0; r < 4; r++)
			for (int k = 0; k < 3; k++) rchk("enable_rst", ra(r, 5'(k * 4)), 32'h0);
		xfer(1, ra(0, rae_pkg::R_DMA_EN_LO), 32'h0000_00FF);
		xfer(1, ra(1, rae_pkg::R_DMA_EN_HI), 32'h8000_0001);
		xfer(1, ra(2, rae_pkg::R_QDMA_EN), 32'hFFFF_FFFF);
		rchk("qdma_en", ra(2, rae_pkg::R_QDMA_EN), 32'h0000_00FF);
		rchk("dma_en_lo", ra(1, rae_pkg::R_DMA_EN_LO), 32'h0);
		rchk("dma_en_hi", ra(1, rae_pkg::R_DMA_EN_HI), 32'h8000_0001);
		xfer(1, rae_pkg::A_CH_LO, 32'hFFFF_FFFF);
		rchk("view_lo", ra(0, rae_pkg::R_VIEW_LO), 32'h0000_00FF);
		rchk("view_lo1", ra(1, rae_pkg::R_VIEW_LO), 32'h0);
		xfer(1, ra(0, rae_pkg::R_VIEW_LO), 32'h0);
		rchk("chan_lo", rae_pkg::A_CH_LO, 32'hFFFF_FF00);
		xfer(1, ra(1, rae_pkg::R_VIEW_HI), 32'hFFFF_FFFF);
		rchk("chan_hi", rae_pkg::A_CH_HI, 32'h8000_0001);
		xfer(1, ra(3, rae_pkg::R_QDMA_EN), 32'h0F);
		xfer(1, rae_pkg::A_CH_Q, 32'hAA);
		rchk("view_q", ra(3, rae_pkg::R_VIEW_Q), 32'h0A);
		xfer(1, ra(3, rae_pkg::R_VIEW_Q), 32'h0);
		rchk("chan_q", rae_pkg::A_CH_Q, 32'hA0);
		rchk("unmapped", 12'h180, 32'h0);
		chk("pslverr", serr, 1);
		xfer(1, rae_pkg::A_CH_LO, 32'hFFFF_FFFF);
		chan_pend <= 64'h1_0000_0120;
		repeat (3) @(posedge ref_clk);
		chk("region_irq", region_irq, 4'h3);
		chk("irq_masked", irq, 0);
		chan_pend <= 64'h100;
		repeat (3) @(posedge ref_clk);
		chk("region_irq0", region_irq, 4'h0);
		xfer(1, rae_pkg::A_IRQ_MASK, 32'h4);
		repeat (2) @(posedge ref_clk);
		chk("irq", irq, 1);
		xfer(1, rae_pkg::A_IRQ_STAT, 32'h4);
		repeat (2) @(posedge ref_clk);
		chk("irq_clr", irq, 0);
		p0 = pulses;
		dma_event_miss_low <= 32'h1;
		pchk(1);
		rchk("err_state", rae_pkg::A_ERR_STATE, 32'h1);
		rchk("irq_stat", rae_pkg::A_IRQ_STAT, 32'h1);
		dma_event_miss_high <= 32'h8000_0000;
		qdma_event_miss <= 8'h01;
		pchk(0);
		xfer(1, rae_pkg::A_EVALUATE_BIT, 32'h1);
		pchk(1);
		xfer(1, rae_pkg::A_EVALUATE_BIT, 32'h0);
		pchk(0);
		{dma_event_miss_low, dma_event_miss_high, qdma_event_miss} <= '0;
		pchk(0);
		rchk("err_state0", rae_pkg::A_ERR_STATE, 32'h0);
		xfer(1, rae_pkg::A_EVALUATE_BIT, 32'h1);
		pchk(0);
		ctrl_err_set <= 17'h10000;
		@(posedge ref_clk);
		ctrl_err_set <= '0;
		pchk(1);
		xfer(1, rae_pkg::A_CE_CLR, 32'h1);
		rchk("flags", rae_pkg::A_CE_FLAGS, 32'h10000);
		xfer(1, rae_pkg::A_CE_CLR, 32'h10000);
		rchk("flags_clr", rae_pkg::A_CE_FLAGS, 32'h0);
		summarize();
	end
endmodule : rae_top_test
